// >>> hw/lcc_apb_slave.sv
// APB slave front end of the loop clock configuration block
`timescale 1ns/1ps
`default_nettype none
module lcc_apb_slave
    import lcc_pkg::*;
(
    input wire logic pclk, // Bus clock
    input wire logic presetn, // Async reset, active low
    input wire logic [LCC_ADDR_W-1:0] paddr, // Byte address
    input wire logic psel, // Slave select
    input wire logic penable, // Access phase
    input wire logic pwrite, // Write when high
    input wire logic [31:0] pwdata, // Write data
    output logic [31:0] prdata, // Read data
    output logic pready, // Transfer done
    output logic pslverr, // Unmapped address
    lcc_bus_if.slave bus // Register access
);
    // ************************************************
    // Decode
    // ************************************************
    wire [15:0] word_idx = paddr[LCC_ADDR_W-1:2];
    wire in_map = (paddr[1:0] == 2'h0) && (word_idx >= LCC_IDX_FB_DIV)
        && (word_idx <= LCC_IDX_CLOCK_OUTPUT_PIN);
    wire setup = psel && !penable;
    wire [31:0] rd_word = (in_map && !pwrite) ? {16'h0000, bus.rdata} : 32'h0000_0000;

    assign bus.sel = word_idx[2:0];
    assign bus.wdata = pwdata[15:0];
    assign bus.wr_stb = psel && penable && pready && pwrite && in_map;

    // ************************************************
    // Answer, one access cycle
    // ************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            if (setup) begin
                prdata <= rd_word;
                pslverr <= !in_map;
            end
        end
    end

    pready_one_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> (pready && psel && penable) ##1 !pready)
        else $error("pready not given in the access cycle");
endmodule // lcc_apb_slave
`default_nettype wire

// >>> hw/lcc_prescaler.sv
// Master clock prescaler feeding the multiplier reference
`timescale 1ns/1ps
`default_nettype none
module lcc_prescaler
    import lcc_pkg::*;
(
    input wire logic pclk, // Block clock
    input wire logic presetn, // Async reset, active low
    input wire logic master_clock_pin, // External master clock
    input wire logic run, // Multiplier enabled
    input wire logic [1:0] ratio, // Active prescale code
    output logic ref_clk // Prescaled reference
);
    logic mclk_s1_q;
    logic mclk_s2_q;
    logic mclk_prev_q;
    logic [1:0] cnt_q;

    // ************************************************
    // Ratio select
    // ************************************************
    wire rise = mclk_s2_q && !mclk_prev_q;
    wire [1:0] half = (ratio == LCC_DIV_2) ? LCC_HALF_DIV_2 :
        (ratio == LCC_DIV_4) ? LCC_HALF_DIV_4 : LCC_HALF_DIV_8;
    wire at_half = (cnt_q == half);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mclk_s1_q <= 1'b0;
            mclk_s2_q <= 1'b0;
            mclk_prev_q <= 1'b0;
        end else begin
            mclk_s1_q <= master_clock_pin;
            mclk_s2_q <= mclk_s1_q;
            mclk_prev_q <= mclk_s2_q;
        end
    end

    // ************************************************
    // Divider, idle while disabled
    // ************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 2'h0;
            ref_clk <= 1'b0;
        end else if (!run) begin
            cnt_q <= 2'h0;
            ref_clk <= 1'b0;
        end else if (ratio == LCC_DIV_1) begin
            cnt_q <= 2'h0;
            ref_clk <= mclk_s2_q;
        end else if (rise) begin
            cnt_q <= at_half ? 2'h0 : cnt_q + 2'h1;
            ref_clk <= at_half ? !ref_clk : ref_clk;
        end
    end

    div_eight_a: assert property (@(posedge pclk) disable iff (!presetn)
        (run && ratio == LCC_DIV_8 && rise && cnt_q != 2'h3) |=> $stable(ref_clk))
        else $error("divide by eight toggled early");
    div_two_a: assert property (@(posedge pclk) disable iff (!presetn)
        (run && ratio == LCC_DIV_2 && rise) |=> (ref_clk != $past(ref_clk)))
        else $error("divide by two missed a toggle");
endmodule // lcc_prescaler
`default_nettype wire

// >>> hw/lcc_top.sv
// Loop clock configuration registers with staged load on enable
`timescale 1ns/1ps
`default_nettype none

module lcc_top
    import lcc_pkg::*;
(
    input wire logic pclk, // Register clock, 100 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic [LCC_ADDR_W-1:0] paddr, // APB byte address
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic master_clock_pin, // External master clock
    input wire logic mult_locked_in, // Raw lock from multiplier
    output logic mult_ref_clk, // Prescaled multiplier input
    output logic mult_run, // Multiplier may lock and run
    output logic [LCC_FB_W-1:0] mult_fb_div, // Active feedback divider
    output logic sys_src_mult, // Core clock from multiplier
    output logic clock_output_pin_enable, // Active clock output enable
    output logic [1:0] clock_output_pin_rate // Active clock output rate
);
    // ************************************************
    // Storage
    // ************************************************
    logic [LCC_FB_W-1:0] pend_fb_q;
    logic [1:0] pend_div_q;
    logic pend_src_q;
    logic [2:0] pend_clock_output_pin_q;
    logic en_q;
    logic en_prev_q;
    logic [1:0] act_div_q;
    logic lock_s1_q;
    logic lock_s2_q;
    logic lock_q;

    lcc_bus_if bus ();

    lcc_apb_slave u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .paddr(paddr),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .bus(bus)
    );

    // ************************************************
    // Write decode
    // ************************************************
    wire wr_fb = bus.wr_stb && (bus.sel == LCC_SEL_FB_DIV);
    wire wr_div = bus.wr_stb && (bus.sel == LCC_SEL_PRESCALE);
    wire wr_src = bus.wr_stb && (bus.sel == LCC_SEL_SRC);
    wire wr_en = bus.wr_stb && (bus.sel == LCC_SEL_ENABLE);
    wire wr_clock_output_pin = bus.wr_stb && (bus.sel == LCC_SEL_CLOCK_OUTPUT_PIN);

    // Enable rising edge against the registered previous value
    wire load = en_q && !en_prev_q;

    // ************************************************
    // Read mux
    // ************************************************
    wire [2:0] act_clock_output_pin = {clock_output_pin_rate, clock_output_pin_enable};
    wire [15:0] rd_fb = {9'h000, pend_fb_q};
    wire [15:0] rd_div = {14'h0000, pend_div_q};
    wire [15:0] rd_src = {15'h0000, pend_src_q};
    wire [15:0] rd_en = {15'h0000, en_q};
    wire [15:0] rd_lock = {15'h0000, lock_q};
    wire [15:0] rd_clock_output_pin = {13'h0000, pend_clock_output_pin_q};
    assign bus.rdata =
        (bus.sel == LCC_SEL_FB_DIV) ? rd_fb :
        (bus.sel == LCC_SEL_PRESCALE) ? rd_div :
        (bus.sel == LCC_SEL_SRC) ? rd_src :
        (bus.sel == LCC_SEL_ENABLE) ? rd_en :
        (bus.sel == LCC_SEL_LOCK) ? rd_lock :
        rd_clock_output_pin;

    // ************************************************
    // Pending registers
    // ************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_fb_q <= LCC_FB_RST;
        end else if (wr_fb) begin
            pend_fb_q <= bus.wdata[LCC_FB_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_div_q <= LCC_PRESCALE_RST;
        end else if (wr_div) begin
            pend_div_q <= bus.wdata[1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_src_q <= LCC_SRC_RST;
        end else if (wr_src) begin
            pend_src_q <= bus.wdata[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_clock_output_pin_q <= LCC_CLOCK_OUTPUT_PIN_RST;
        end else if (wr_clock_output_pin) begin
            pend_clock_output_pin_q <= bus.wdata[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= LCC_ENABLE_RST;
            en_prev_q <= LCC_ENABLE_RST;
        end else begin
            if (wr_en) begin
                en_q <= bus.wdata[0];
            end
            en_prev_q <= en_q;
        end
    end

    // ************************************************
    // Active copies, loaded together on enable rise
    // ************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mult_fb_div <= LCC_FB_RST;
            act_div_q <= LCC_PRESCALE_RST;
            sys_src_mult <= LCC_SRC_RST;
            clock_output_pin_enable <= LCC_CLOCK_OUTPUT_PIN_RST[LCC_CLOCK_OUTPUT_PIN_EN_BIT];
            clock_output_pin_rate <= LCC_CLOCK_OUTPUT_PIN_RST[LCC_CLOCK_OUTPUT_PIN_RATE_LSB +: 2];
        end else if (load) begin
            mult_fb_div <= pend_fb_q;
            act_div_q <= pend_div_q;
            sys_src_mult <= pend_src_q;
            clock_output_pin_enable <= pend_clock_output_pin_q[LCC_CLOCK_OUTPUT_PIN_EN_BIT];
            clock_output_pin_rate <= pend_clock_output_pin_q[LCC_CLOCK_OUTPUT_PIN_RATE_LSB +: 2];
        end
    end

    // ************************************************
    // Run control and lock status
    // ************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mult_run <= 1'b0;
        end else begin
            mult_run <= en_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_s1_q <= 1'b0;
            lock_s2_q <= 1'b0;
            lock_q <= 1'b0;
        end else begin
            lock_s1_q <= mult_locked_in;
            lock_s2_q <= lock_s1_q;
            lock_q <= en_q && mult_run && lock_s2_q;
        end
    end

    // Reference stays idle while the multiplier is off
    lcc_prescaler u_presc (
        .pclk(pclk),
        .presetn(presetn),
        .master_clock_pin(master_clock_pin),
        .run(mult_run),
        .ratio(act_div_q),
        .ref_clk(mult_ref_clk)
    );

    // ************************************************
    // Checks
    // ************************************************
    presc_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_div && !load) |=> (act_div_q == $past(act_div_q)))
        else $error("prescale took effect without enable rise");

    src_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(en_q && !en_prev_q) |=> $stable(sys_src_mult))
        else $error("source changed without enable rise");

    load_all_a: assert property (@(posedge pclk) disable iff (!presetn)
        load |=> (mult_fb_div == $past(pend_fb_q)) && (act_div_q == $past(pend_div_q))
            && (sys_src_mult == $past(pend_src_q))
            && ({clock_output_pin_rate, clock_output_pin_enable} == $past(pend_clock_output_pin_q)))
        else $error("pending settings not loaded together");

    src_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        (load && pend_src_q) |=> sys_src_mult ##1 (sys_src_mult || $past(load)))
        else $error("multiplier source not routed");

    edge_once_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && bus.wdata[0] && !en_q) |=> load ##1 (!load || !en_prev_q))
        else $error("enable rise not detected in one cycle");

    no_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
        !en_q |=> !mult_run)
        else $error("multiplier running while disabled");

    clk_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!en_q ##1 !en_q) |=> !mult_ref_clk)
        else $error("reference clock active while disabled");

    lock_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        !en_q |=> !lock_q)
        else $error("lock flag set while disabled");

    reset_zero_a: assert property (@(posedge pclk)
        $rose(presetn) |-> (pend_div_q == 2'h0) && !pend_src_q && !en_q)
        else $error("reset values not zero");

    fb_reset_a: assert property (@(posedge pclk)
        $rose(presetn) |-> (pend_fb_q == LCC_FB_RST) && (mult_fb_div == LCC_FB_RST))
        else $error("feedback divider not 96 after reset");

    act_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(act_clock_output_pin) |-> $past(load))
        else $error("clock output settings changed without load");

    run_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        en_q |=> mult_run)
        else $error("multiplier not running after enable");

    ref_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        !mult_run |=> !mult_ref_clk)
        else $error("reference clock active while stopped");

    lock_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
        lock_q |-> $past(lock_s2_q) && $past(mult_run))
        else $error("lock flag without synced lock");

    lock_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
        !lock_s2_q |=> !lock_q)
        else $error("lock flag held after lock loss");

    lock_reset_a: assert property (@(posedge pclk)
        $rose(presetn) |-> !mult_run && !lock_q)
        else $error("multiplier or lock active after reset");

    fb_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !load |=> $stable(mult_fb_div))
        else $error("feedback divider changed without load");

    div_act_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !load |=> $stable(act_div_q))
        else $error("active prescale changed without load");

    load_once_a: assert property (@(posedge pclk) disable iff (!presetn)
        load |=> !load)
        else $error("load lasted more than one cycle");

    en_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en |=> (en_q == $past(bus.wdata[0])))
        else $error("enable bit not written");

    fb_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_fb |=> (pend_fb_q == $past(bus.wdata[LCC_FB_W-1:0])))
        else $error("feedback divider not written");

    div_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_div |=> (pend_div_q == $past(bus.wdata[1:0])))
        else $error("prescale code not written");

    src_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_src |=> (pend_src_q == $past(bus.wdata[0])))
        else $error("source select not written");

    ck_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_clock_output_pin |=> (pend_clock_output_pin_q == $past(bus.wdata[2:0])))
        else $error("clock output setting not written");

    div_pend_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !wr_div |=> $stable(pend_div_q))
        else $error("pending prescale changed without write");

    src_pend_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !wr_src |=> $stable(pend_src_q))
        else $error("pending source changed without write");
endmodule // lcc_top
`default_nettype wire

// >>> pkg/lcc_bus_if.sv
// Internal register access carrier between bus slave and register file
`timescale 1ns/1ps
`default_nettype none
interface lcc_bus_if;
    logic wr_stb;
    logic [2:0] sel;
    logic [15:0] wdata;
    logic [15:0] rdata;
    modport slave (output wr_stb, output sel, output wdata, input rdata);
    modport regs (input wr_stb, input sel, input wdata, output rdata);
endinterface
`default_nettype wire

// >>> pkg/lcc_pkg.sv
// Constants for the loop clock configuration block
package lcc_pkg;
    // Printed register indices; byte address is four times the index
    localparam logic [15:0] LCC_IDX_FB_DIV = 16'hF000;
    localparam logic [15:0] LCC_IDX_PRESCALE = 16'hF001;
    localparam logic [15:0] LCC_IDX_SRC = 16'hF002;
    localparam logic [15:0] LCC_IDX_ENABLE = 16'hF003;
    localparam logic [15:0] LCC_IDX_LOCK = 16'hF004;
    localparam logic [15:0] LCC_IDX_CLOCK_OUTPUT_PIN = 16'hF005;
    localparam int LCC_ADDR_W = 18;
    // Low three index bits pick the register inside the block
    localparam logic [2:0] LCC_SEL_FB_DIV = 3'h0;
    localparam logic [2:0] LCC_SEL_PRESCALE = 3'h1;
    localparam logic [2:0] LCC_SEL_SRC = 3'h2;
    localparam logic [2:0] LCC_SEL_ENABLE = 3'h3;
    localparam logic [2:0] LCC_SEL_LOCK = 3'h4;
    localparam logic [2:0] LCC_SEL_CLOCK_OUTPUT_PIN = 3'h5;
    // Field widths and positions
    localparam int LCC_FB_W = 7;
    localparam int LCC_CLOCK_OUTPUT_PIN_EN_BIT = 0;
    localparam int LCC_CLOCK_OUTPUT_PIN_RATE_LSB = 1;
    // Reset values
    localparam logic [6:0] LCC_FB_RST = 7'h60;
    localparam logic [1:0] LCC_PRESCALE_RST = 2'h0;
    localparam logic LCC_SRC_RST = 1'h0;
    localparam logic LCC_ENABLE_RST = 1'h0;
    localparam logic [2:0] LCC_CLOCK_OUTPUT_PIN_RST = 3'h0;
    // Prescale codes
    localparam logic [1:0] LCC_DIV_1 = 2'h0;
    localparam logic [1:0] LCC_DIV_2 = 2'h1;
    localparam logic [1:0] LCC_DIV_4 = 2'h2;
    localparam logic [1:0] LCC_DIV_8 = 2'h3;
    // Rising input edges between output toggles, minus one
    localparam logic [1:0] LCC_HALF_DIV_2 = 2'h0;
    localparam logic [1:0] LCC_HALF_DIV_4 = 2'h1;
    localparam logic [1:0] LCC_HALF_DIV_8 = 2'h3;
endpackage

// >>> sim/lcc_top_tb.sv
// Self-checking bench for the loop clock configuration block
`timescale 1ns/1ps
`default_nettype none
module lcc_top_tb
    import lcc_pkg::*;
();
    // ****************************************
    // Signals
    // ****************************************
    logic pclk, presetn, psel, penable, pwrite, mult_locked_in;
    logic master_clock_pin = 1'b0;
    logic [1:0] pin_cnt_q = 2'h0;
    logic [LCC_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, mult_ref_clk, mult_run, sys_src_mult, clock_output_pin_enable;
    logic [LCC_FB_W-1:0] mult_fb_div;
    logic [1:0] clock_output_pin_rate;
    int error_cnt = 0;
    int total_checks = 0;
    logic [15:0] lfsr_q = 16'h96C4;
    logic [6:0] a_fb;
    logic a_src;
    logic [2:0] a_ck;

    lcc_top lcc_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .master_clock_pin(master_clock_pin),
        .mult_locked_in(mult_locked_in), .mult_ref_clk(mult_ref_clk), .mult_run(mult_run),
        .mult_fb_div(mult_fb_div), .sys_src_mult(sys_src_mult),
        .clock_output_pin_enable(clock_output_pin_enable), .clock_output_pin_rate(clock_output_pin_rate));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Master clock of period 8 pclk cycles
    always @(posedge pclk) begin
        pin_cnt_q <= pin_cnt_q + 2'h1;
        if (pin_cnt_q == 2'h3) master_clock_pin <= ~master_clock_pin;
    end

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[0] ^ s[2] ^ s[3] ^ s[5], s[15:1]};
    endfunction

    task automatic end_sim();
        if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            error_cnt++;
        end
    endtask

    task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            $display("wrong value pready expected 1 seen %b", pready);
            error_cnt++;
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, idx, d, rd, er);
        chk("write error", 32'h0, {31'h0, er});
    endtask

    task automatic rd_chk(input string name, input logic [15:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        logic er;
        apb(1'b0, idx, 32'h0, rd, er);
        chk(name, exp, rd);
        chk("read error", 32'h0, {31'h0, er});
    endtask

    task automatic chk_act();
        chk("active fb", {25'h0, a_fb}, {25'h0, mult_fb_div});
        chk("active src", {31'h0, a_src}, {31'h0, sys_src_mult});
        chk("active clock_output_pin", {29'h0, a_ck}, {29'h0, clock_output_pin_rate, clock_output_pin_enable});
    endtask

    // Cycles from the call to the next reference rising edge
    task automatic ref_rise(output int n);
        logic prv;
        logic ok;
        n = 0;
        ok = 1'b0;
        prv = mult_ref_clk;
        while (!ok && n < 400) begin
            @(posedge pclk);
            n++;
            ok = (prv === 1'b0 && mult_ref_clk === 1'b1);
            prv = mult_ref_clk;
        end
        if (!ok) begin
            $display("wrong value ref edge expected 1 seen 0");
            error_cnt++;
            end_sim();
        end
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [31:0] v, rd;
        logic er;
        int n, hi;
        logic [15:0] idx_tab [6];
        logic [31:0] rst_tab [6];
        idx_tab = '{LCC_IDX_FB_DIV, LCC_IDX_PRESCALE, LCC_IDX_SRC, LCC_IDX_ENABLE,
                    LCC_IDX_LOCK, LCC_IDX_CLOCK_OUTPUT_PIN};
        rst_tab = '{32'h60, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0;
        mult_locked_in = 1'b0;
        presetn = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        a_fb = 7'h60;
        a_src = 1'b0;
        a_ck = 3'h0;
        chk("run after reset", 32'h0, {31'h0, mult_run});
        chk_act();
        for (int i = 0; i < 6; i++) rd_chk("reset value", idx_tab[i], rst_tab[i]);
        apb(1'b0, 16'hF006, 32'h0, rd, er);
        chk("unmapped error", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        wr(LCC_IDX_LOCK, 32'h1);
        rd_chk("lock after write", LCC_IDX_LOCK, 32'h0);
        for (int code = 0; code < 4; code++) begin
            lfsr_q = lfsr_next(lfsr_q);
            v[15:0] = lfsr_q;
            lfsr_q = lfsr_next(lfsr_q);
            v[31:16] = lfsr_q;
            wr(LCC_IDX_FB_DIV, v);
            wr(LCC_IDX_PRESCALE, {v[31:2], code[1:0]});
            wr(LCC_IDX_SRC, {v[31:1], code[0]});
            wr(LCC_IDX_CLOCK_OUTPUT_PIN, v >> 8);
            rd_chk("pending fb", LCC_IDX_FB_DIV, {25'h0, v[6:0]});
            rd_chk("pending prescale", LCC_IDX_PRESCALE, {30'h0, code[1:0]});
            rd_chk("pending src", LCC_IDX_SRC, {31'h0, code[0]});
            rd_chk("pending clock_output_pin", LCC_IDX_CLOCK_OUTPUT_PIN, {29'h0, v[10:8]});
            chk_act();
            wr(LCC_IDX_ENABLE, 32'h0);
            mult_locked_in <= 1'b1;
            repeat (6) @(posedge pclk);
            chk("run while disabled", 32'h0, {31'h0, mult_run});
            chk_act();
            rd_chk("lock while disabled", LCC_IDX_LOCK, 32'h0);
            hi = 0;
            repeat (64) begin
                @(posedge pclk);
                if (mult_ref_clk !== 1'b0) hi++;
            end
            chk("ref while disabled", 32'h0, hi);
            wr(LCC_IDX_ENABLE, 32'h1);
            a_fb = v[6:0];
            a_src = code[0];
            a_ck = v[10:8];
            repeat (2) @(posedge pclk);
            chk("run when enabled", 32'h1, {31'h0, mult_run});
            chk_act();
            rd_chk("lock when enabled", LCC_IDX_LOCK, 32'h1);
            ref_rise(n);
            ref_rise(n);
            ref_rise(n);
            chk("ref period", 32'd8 << code, n);
            wr(LCC_IDX_FB_DIV, ~v);
            wr(LCC_IDX_SRC, {31'h0, ~code[0]});
            wr(LCC_IDX_ENABLE, 32'h1);
            repeat (2) @(posedge pclk);
            chk_act();
            mult_locked_in <= 1'b0;
        end
        // Second reset in mid-run, after active settings moved away from reset
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        a_fb = 7'h60;
        a_src = 1'b0;
        a_ck = 3'h0;
        chk("run after second reset", 32'h0, {31'h0, mult_run});
        chk_act();
        for (int i = 0; i < 6; i++) rd_chk("second reset", idx_tab[i], rst_tab[i]);
        end_sim();
    end
endmodule // lcc_top_tb
`default_nettype wire
